// file: rtl/cbc_pkg.sv
// shared constants for the bus-control front end
package cbc_pkg;
    // phase timing: each clock phase lasts at least this long
    localparam int PHASE_NS = 250;
    localparam int REF_CLK_MHZ = 40;
    localparam int PHASE_CYCLES = (PHASE_NS * REF_CLK_MHZ + 999) / 1000;

    // initialization length after the reset input rises, in bus cycles
    localparam logic [2:0] RESET_INIT_CYCLES = 3'h6;

    // vector addresses, low byte location of each pair
    localparam logic [15:0] VEC_NMI = 16'hFFFA;
    localparam logic [15:0] VEC_RESET = 16'hFFFC;
    localparam logic [15:0] VEC_IRQ = 16'hFFFE;

    // stack page and stack pointer value after reset
    localparam logic [7:0] STACK_PAGE = 8'h01;
    localparam logic [7:0] SP_RESET = 8'hFF;

    // status bit positions and value after reset
    localparam int STAT_MASK_BIT = 2;
    localparam int STAT_OVF_BIT = 6;
    localparam logic [7:0] STATUS_RESET = 8'h34;

    // addressing modes reported by the outside opcode decoder
    typedef enum logic [2:0] {
        MODE_IMPLIED = 3'b000,
        MODE_ACCUM = 3'b001,
        MODE_IMMED = 3'b010,
        MODE_ZPAGE = 3'b011,
        MODE_ZPAGE_IDX = 3'b100,
        MODE_ABS = 3'b101,
        MODE_ABS_IDX = 3'b110,
        MODE_SPARE = 3'b111
    } cbc_mode_e;

    // bus sequencer states
    typedef enum logic [3:0] {
        ST_RST_HOLD = 4'b0000,
        ST_RST_INIT = 4'b0001,
        ST_VEC_LO = 4'b0010,
        ST_VEC_HI = 4'b0011,
        ST_FETCH = 4'b0100,
        ST_DECODE = 4'b0101,
        ST_ZP_IDX = 4'b0110,
        ST_ABS_HI = 4'b0111,
        ST_DATA = 4'b1000,
        ST_INT_DUMMY = 4'b1001,
        ST_PUSH_HI = 4'b1010,
        ST_PUSH_LO = 4'b1011,
        ST_PUSH_STAT = 4'b1100
    } cbc_state_e;
endpackage : cbc_pkg

// file: rtl/cbc_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
// two-phase non-overlapping cycle generator driven by a free-running reference clock counter
module cbc_phase_gen
    import cbc_pkg::*;
#(
    parameter int PHASE_LEN = PHASE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    output logic phase1,
    output logic phase2,
    output logic phase1End,
    output logic phase2End
);
    logic [15:0] countReg;
    logic lastTick;

    assign lastTick = (countReg == 16'(PHASE_LEN - 1));

    // phase length counter
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            countReg <= 16'h0000;
        end else if (lastTick) begin
            countReg <= 16'h0000;
        end else begin
            countReg <= countReg + 16'h0001;
        end
    end

    // phase levels, never high together
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase1 <= 1'b1;
            phase2 <= 1'b0;
        end else if (lastTick) begin
            phase1 <= phase2;
            phase2 <= phase1;
        end
    end

    // one-cycle strobes at the close of each phase
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase1End <= 1'b0;
            phase2End <= 1'b0;
        end else begin
            phase1End <= lastTick && phase1;
            phase2End <= lastTick && phase2;
        end
    end
endmodule : cbc_phase_gen
`default_nettype wire

// file: rtl/cbc_bus_core.sv
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_core
    import cbc_pkg::*;
#(
    parameter int PHASE_LEN = PHASE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic resetInputN,
    input wire logic holdIn,
    input wire logic irqN,
    input wire logic nmiN,
    input wire logic setOverflowN,
    input wire logic dataOutputGate,
    input wire logic [7:0] dataIn,
    input wire logic [2:0] decodeMode,
    input wire logic decodeStore,
    input wire logic decodeUseY,
    input wire logic [7:0] indexX,
    input wire logic [7:0] indexY,
    input wire logic [7:0] storeData,
    input wire logic statusLoad,
    input wire logic [7:0] statusIn,
    output logic phase1Out,
    output logic phase2Out,
    output logic [15:0] addrOut,
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic readWrite,
    output logic opFetch,
    output logic [7:0] opcodeOut,
    output logic [7:0] operandOut,
    output logic operandValid,
    output logic [15:0] effAddrOut,
    output logic [7:0] statusOut
);
    // index arithmetic
    function automatic logic [15:0] zeroPageIndex(input logic [7:0] base, input logic [7:0] idx);
        logic [7:0] sum;
        sum = base + idx;
        return {8'h00, sum};
    endfunction : zeroPageIndex

    function automatic logic [15:0] absIndex(input logic [15:0] base, input logic [7:0] idx);
        return base + {8'h00, idx};
    endfunction : absIndex

    logic phase1;
    logic phase2;
    logic phase1End;
    logic phase2End;

    cbc_state_e stateReg;
    cbc_state_e stateNext;
    logic [15:0] pcReg;
    logic [15:0] pcNext;
    logic [7:0] spReg;
    logic [7:0] spNext;
    logic [7:0] baseLoReg;
    logic [7:0] baseLoNext;
    logic [15:0] eaReg;
    logic [15:0] eaNext;
    logic [15:0] vecReg;
    logic [15:0] vecNext;
    logic [2:0] initCountReg;
    logic [2:0] initCountNext;
    logic [15:0] addrNext;
    logic writeNext;
    logic syncNext;
    logic [7:0] wdataNext;
    logic operandNext;
    logic [7:0] operandDataNext;
    logic setMask;
    logic takeNmi;
    logic instrDone;
    logic stall;
    logic advance;
    logic nmiPrevReg;
    logic nmiPendReg;
    logic irqSampReg;
    logic soPrevReg;
    logic intWanted;
    logic [7:0] idxSel;
    logic [15:0] absBase;

    cbc_phase_gen #(
        .PHASE_LEN(PHASE_LEN)
    ) u_phase (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .phase1(phase1),
        .phase2(phase2),
        .phase1End(phase1End),
        .phase2End(phase2End)
    );

    // phase outputs registered once more
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase1Out <= 1'b0;
            phase2Out <= 1'b0;
        end else begin
            phase1Out <= phase1;
            phase2Out <= phase2;
        end
    end

    // same stall freezes an opcode fetch cycle
    assign stall = readWrite && !holdIn;
    assign advance = phase2End && !stall;
    assign idxSel = decodeUseY ? indexY : indexX;
    assign absBase = {dataIn, baseLoReg};
    assign intWanted = holdIn && (nmiPendReg || (irqSampReg && !statusOut[STAT_MASK_BIT]));

    // interrupt inputs sampled at end of phase two
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            nmiPrevReg <= 1'b1;
            irqSampReg <= 1'b0;
        end else if (phase2End) begin
            nmiPrevReg <= nmiN;
            irqSampReg <= !irqN;
        end
    end

    // non-maskable edge latch, new edge wins over clear
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            nmiPendReg <= 1'b0;
        end else if (phase2End && nmiPrevReg && !nmiN) begin
            nmiPendReg <= 1'b1;
        end else if (advance && takeNmi) begin
            nmiPendReg <= 1'b0;
        end
    end

    // set-overflow input history, end of phase one
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            soPrevReg <= 1'b1;
        end else if (phase1End) begin
            soPrevReg <= setOverflowN;
        end
    end

    // status register, hardware sets win over outside loads
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            statusOut <= STATUS_RESET;
        end else begin
            statusOut <= statusLoad ? statusIn : statusOut;
            if (advance && setMask) begin
                statusOut[STAT_MASK_BIT] <= 1'b1;
            end
            if (phase1End && soPrevReg && !setOverflowN) begin
                statusOut[STAT_OVF_BIT] <= 1'b1;
            end
        end
    end

    // sequencer next state and next bus cycle
    always_comb begin
        stateNext = stateReg;
        pcNext = pcReg;
        spNext = spReg;
        baseLoNext = baseLoReg;
        eaNext = eaReg;
        vecNext = vecReg;
        initCountNext = initCountReg;
        operandNext = 1'b0;
        operandDataNext = operandOut;
        setMask = 1'b0;
        takeNmi = 1'b0;
        instrDone = 1'b0;
        unique case (stateReg)
            ST_RST_HOLD: begin
                initCountNext = 3'h0;
                if (resetInputN) begin
                    stateNext = ST_RST_INIT;
                end
            end
            // init cycles, then mask and reset vector
            ST_RST_INIT: begin
                initCountNext = initCountReg + 3'h1;
                if (initCountReg == RESET_INIT_CYCLES - 3'h1) begin
                    setMask = 1'b1;
                    vecNext = VEC_RESET;
                    spNext = SP_RESET;
                    stateNext = ST_VEC_LO;
                end
            end
            ST_VEC_LO: begin
                pcNext = {pcReg[15:8], dataIn};
                stateNext = ST_VEC_HI;
            end
            ST_VEC_HI: begin
                pcNext = {dataIn, pcReg[7:0]};
                stateNext = ST_FETCH;
            end
            ST_FETCH: begin
                pcNext = pcReg + 16'h0001;
                stateNext = ST_DECODE;
            end
            ST_DECODE: begin
                unique case (cbc_mode_e'(decodeMode))
                    // single-byte modes, byte two not consumed
                    MODE_IMPLIED, MODE_ACCUM, MODE_SPARE: begin
                        instrDone = 1'b1;
                    end
                    MODE_IMMED: begin
                        pcNext = pcReg + 16'h0001;
                        operandNext = 1'b1;
                        operandDataNext = dataIn;
                        instrDone = 1'b1;
                    end
                    MODE_ZPAGE: begin
                        pcNext = pcReg + 16'h0001;
                        eaNext = {8'h00, dataIn};
                        stateNext = ST_DATA;
                    end
                    MODE_ZPAGE_IDX: begin
                        pcNext = pcReg + 16'h0001;
                        baseLoNext = dataIn;
                        stateNext = ST_ZP_IDX;
                    end
                    MODE_ABS, MODE_ABS_IDX: begin
                        pcNext = pcReg + 16'h0001;
                        baseLoNext = dataIn;
                        stateNext = ST_ABS_HI;
                    end
                endcase
            end
            // carry dropped, stays in page zero
            ST_ZP_IDX: begin
                eaNext = zeroPageIndex(baseLoReg, idxSel);
                stateNext = ST_DATA;
            end
            ST_ABS_HI: begin
                pcNext = pcReg + 16'h0001;
                eaNext = (cbc_mode_e'(decodeMode) == MODE_ABS_IDX) ?
                    absIndex(absBase, idxSel) : absBase;
                stateNext = ST_DATA;
            end
            ST_DATA: begin
                if (!decodeStore) begin
                    operandNext = 1'b1;
                    operandDataNext = dataIn;
                end
                instrDone = 1'b1;
            end
            ST_INT_DUMMY: begin
                stateNext = ST_PUSH_HI;
            end
            ST_PUSH_HI: begin
                spNext = spReg - 8'h01;
                stateNext = ST_PUSH_LO;
            end
            ST_PUSH_LO: begin
                spNext = spReg - 8'h01;
                stateNext = ST_PUSH_STAT;
            end
            ST_PUSH_STAT: begin
                spNext = spReg - 8'h01;
                setMask = 1'b1;
                takeNmi = nmiPendReg;
                vecNext = nmiPendReg ? VEC_NMI : VEC_IRQ;
                stateNext = ST_VEC_LO;
            end
            default: begin
                stateNext = ST_RST_HOLD;
            end
        endcase
        // interrupt begins after the instruction completes
        if (instrDone) begin
            stateNext = intWanted ? ST_INT_DUMMY : ST_FETCH;
        end
    end

    // bus cycle content for the state about to start
    always_comb begin
        addrNext = pcNext;
        writeNext = 1'b0;
        syncNext = 1'b0;
        wdataNext = 8'h00;
        unique case (stateNext)
            ST_VEC_LO: addrNext = vecNext;
            ST_VEC_HI: addrNext = vecNext | 16'h0001;
            ST_FETCH: syncNext = 1'b1;
            ST_ZP_IDX: addrNext = {8'h00, baseLoNext};
            ST_DATA: begin
                addrNext = eaNext;
                writeNext = decodeStore;
                wdataNext = storeData;
            end
            ST_PUSH_HI: begin
                addrNext = {STACK_PAGE, spNext};
                writeNext = 1'b1;
                wdataNext = pcNext[15:8];
            end
            ST_PUSH_LO: begin
                addrNext = {STACK_PAGE, spNext};
                writeNext = 1'b1;
                wdataNext = pcNext[7:0];
            end
            ST_PUSH_STAT: begin
                addrNext = {STACK_PAGE, spNext};
                writeNext = 1'b1;
                wdataNext = statusOut;
            end
            default: begin
                addrNext = pcNext;
            end
        endcase
    end

    // reset input low forces the idle read state
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stateReg <= ST_RST_HOLD;
            pcReg <= 16'h0000;
            spReg <= SP_RESET;
            baseLoReg <= 8'h00;
            eaReg <= 16'h0000;
            vecReg <= VEC_RESET;
            initCountReg <= 3'h0;
        end else if (!resetInputN) begin
            stateReg <= ST_RST_HOLD;
            initCountReg <= 3'h0;
        end else if (advance) begin
            stateReg <= stateNext;
            pcReg <= pcNext;
            spReg <= spNext;
            baseLoReg <= baseLoNext;
            eaReg <= eaNext;
            vecReg <= vecNext;
            initCountReg <= initCountNext;
        end
    end

    // bus outputs change only at a cycle boundary, except direction and fetch flag forced while reset input low
    // direction high for reads, low for writes
    // fetch indicator held for the whole cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            addrOut <= 16'h0000;
            readWrite <= 1'b1;
            opFetch <= 1'b0;
            dataOut <= 8'h00;
        end else if (!resetInputN) begin
            readWrite <= 1'b1;
            opFetch <= 1'b0;
        end else if (advance) begin
            addrOut <= addrNext;
            readWrite <= !writeNext;
            opFetch <= syncNext;
            dataOut <= wdataNext;
        end
    end

    // read cycles keep drivers off, tracks the direction flop
    // no drive while reset input low
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dataOe <= 1'b0;
        end else begin
            dataOe <= dataOutputGate && resetInputN && (advance ? writeNext : !readWrite);
        end
    end

    // opcode capture at the end of the fetch cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            opcodeOut <= 8'h00;
        end else if (advance && stateReg == ST_FETCH && resetInputN) begin
            opcodeOut <= dataIn;
        end
    end

    // operand delivery and effective address report
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            operandOut <= 8'h00;
            operandValid <= 1'b0;
            effAddrOut <= 16'h0000;
        end else begin
            operandValid <= advance && operandNext && resetInputN;
            if (advance && resetInputN) begin
                operandOut <= operandDataNext;
                effAddrOut <= eaNext;
            end
        end
    end
endmodule : cbc_bus_core
`default_nettype wire

// file: tb/cbc_bus_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_core_checker
    import cbc_pkg::*;
#(
    parameter int PHASE_LEN = PHASE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic resetInputN,
    input wire logic holdIn,
    input wire logic setOverflowN,
    input wire logic dataOutputGate,
    input wire logic phase1Out,
    input wire logic phase2Out,
    input wire logic [15:0] addrOut,
    input wire logic dataOe,
    input wire logic readWrite,
    input wire logic opFetch,
    input wire logic [7:0] statusOut
);
    localparam int CYC4 = 2 * PHASE_LEN + 4;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // high byte read follows the low byte
    sequence vecHi(logic [15:0] v);
        ##[1:CYC4] (addrOut == v + 16'h0001) && readWrite;
    endsequence
    AST_DATA_GATE: assert property (
        dataOe |-> $past(dataOutputGate) && !readWrite && $past(resetInputN))
        else $error("data drive without gate or in read");
    AST_RESET_READ: assert property (
        !resetInputN [*3] |-> readWrite && !dataOe)
        else $error("write while reset input low");
    AST_BUS_BOUNDARY: assert property (
        $changed(addrOut) |-> phase1Out)
        else $error("address moved outside cycle start");
    AST_SYNC_RISE: assert property (
        $rose(opFetch) |-> phase1Out && readWrite)
        else $error("fetch flag rose outside phase one");
    AST_SYNC_STAYS: assert property (
        $rose(phase2Out) && opFetch && resetInputN |-> (opFetch || !resetInputN) [*3])
        else $error("fetch flag dropped inside cycle");
    AST_HOLD_STALL: assert property (
        $fell(phase2Out) && $past(readWrite) && !$past(holdIn) |-> $stable(addrOut) [*3])
        else $error("read cycle not stalled by hold");
    AST_WRITE_GOES: assert property (
        $fell(phase2Out) && !$past(readWrite) |-> $changed(addrOut) || readWrite)
        else $error("write cycle stalled");
    AST_IRQ_VEC: assert property (
        $rose(addrOut == VEC_IRQ) |-> statusOut[STAT_MASK_BIT] ##0 vecHi(VEC_IRQ))
        else $error("maskable vector pair wrong");
    AST_NMI_VEC: assert property (
        $rose(addrOut == VEC_NMI) |-> statusOut[STAT_MASK_BIT] ##0 vecHi(VEC_NMI))
        else $error("non-maskable vector pair wrong");
    AST_RST_VEC: assert property (
        $rose(addrOut == VEC_RESET) |-> statusOut[STAT_MASK_BIT] ##0 vecHi(VEC_RESET))
        else $error("reset vector pair wrong");
    AST_OVF_SET: assert property (
        $fell(setOverflowN) |-> ##[1:CYC4] statusOut[STAT_OVF_BIT])
        else $error("overflow bit not set");
endmodule : cbc_bus_core_checker

bind cbc_bus_core cbc_bus_core_checker #(.PHASE_LEN(PHASE_LEN)) cbc_bus_core_checker_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .resetInputN(resetInputN), .holdIn(holdIn),
    .setOverflowN(setOverflowN), .dataOutputGate(dataOutputGate), .phase1Out(phase1Out),
    .phase2Out(phase2Out), .addrOut(addrOut), .dataOe(dataOe), .readWrite(readWrite),
    .opFetch(opFetch), .statusOut(statusOut));
`default_nettype wire

// file: tb/cbc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbc_mem_model (
    input wire logic ref_clk,
    input wire logic phase2Out,
    input wire logic [15:0] addrOut,
    input wire logic readWrite,
    input wire logic dataOe,
    input wire logic [7:0] dataOut,
    output logic [7:0] dataIn
);
    logic [7:0] memArr [0:65535];
    // filler everywhere, program and vectors on top
    initial begin
        for (int i = 0; i < 65536; i++) begin
            memArr[i] = 8'hEA;
        end
        memArr[16'h1234] = 8'hA5;
        memArr[16'h1235] = 8'hF0;
        memArr[16'h1236] = 8'h12;
        memArr[16'hFFFA] = 8'h00;
        memArr[16'hFFFB] = 8'h30;
        memArr[16'hFFFC] = 8'h34;
        memArr[16'hFFFD] = 8'h12;
        memArr[16'hFFFE] = 8'h00;
        memArr[16'hFFFF] = 8'h20;
    end
    // store only what the device really drives
    always @(posedge ref_clk) begin
        if (phase2Out && !readWrite && dataOe) begin
            memArr[addrOut] <= dataOut;
        end
    end
    // released read line shows the inverse, not a stale value
    assign dataIn = readWrite ? memArr[addrOut] : ~dataOut;
endmodule : cbc_mem_model
`default_nettype wire

// file: tb/cbc_bus_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_core_bench
    import cbc_pkg::*;
;
    logic ref_clk, reset_n, resetInputN, holdIn, irqN, nmiN, setOverflowN, dataOutputGate;
    logic decodeStore, decodeUseY, statusLoad, phase1Out, phase2Out, dataOe, readWrite;
    logic opFetch, operandValid;
    logic [2:0] decodeMode;
    logic [7:0] dataIn, indexX, indexY, storeData, statusIn, dataOut, opcodeOut;
    logic [7:0] operandOut, statusOut;
    logic [15:0] addrOut, effAddrOut;
    int err_count, n_tests;
    int nValid;
    // operand strobe pulses seen
    always @(posedge ref_clk) begin
        if (operandValid === 1'b1) nValid++;
    end
    cbc_bus_core #(.PHASE_LEN(4)) cbc_bus_core_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .resetInputN(resetInputN), .holdIn(holdIn), .irqN(irqN), .nmiN(nmiN),
        .setOverflowN(setOverflowN), .dataOutputGate(dataOutputGate), .dataIn(dataIn),
        .decodeMode(decodeMode), .decodeStore(decodeStore), .decodeUseY(decodeUseY),
        .indexX(indexX), .indexY(indexY), .storeData(storeData), .statusLoad(statusLoad),
        .statusIn(statusIn), .phase1Out(phase1Out), .phase2Out(phase2Out), .addrOut(addrOut),
        .dataOut(dataOut), .dataOe(dataOe), .readWrite(readWrite), .opFetch(opFetch),
        .opcodeOut(opcodeOut), .operandOut(operandOut), .operandValid(operandValid),
        .effAddrOut(effAddrOut), .statusOut(statusOut));
    cbc_mem_model cbc_mem_model_inst (.ref_clk(ref_clk), .phase2Out(phase2Out),
        .addrOut(addrOut), .readWrite(readWrite), .dataOe(dataOe), .dataOut(dataOut),
        .dataIn(dataIn));
    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // step just past the next cycle boundary, still in phase one
    task next_cyc;
        for (int i = 0; i < 20 && !phase2Out; i++) @(posedge ref_clk);
        for (int i = 0; i < 20 && phase2Out; i++) @(posedge ref_clk);
        #1;
    endtask : next_cyc
    // pulse the reset input and run to the first opcode fetch
    task go(input logic [2:0] m, input logic y, input logic st);
        int n;
        @(posedge ref_clk);
        decodeMode <= m;
        decodeUseY <= y;
        decodeStore <= st;
        resetInputN <= 1'b0;
        statusLoad <= 1'b1;
        statusIn <= 8'h00;
        @(posedge ref_clk);
        statusLoad <= 1'b0;
        repeat (3) next_cyc();
        chk(16'(readWrite), 16'h0001);
        @(posedge ref_clk);
        resetInputN <= 1'b1;
        n = 0;
        do begin
            next_cyc();
            n++;
        end while (addrOut !== VEC_RESET && n < 12);
        chk(16'(n == 6 || n == 7), 16'h0001);
        next_cyc();
        chk(addrOut, 16'hFFFD);
        next_cyc();
        chk(addrOut, 16'h1234);
        chk(16'(opFetch), 16'h0001);
        chk(16'(statusOut[STAT_MASK_BIT]), 16'h0001);
    endtask : go
    // every mode code: cycle count, last address, next fetch
    task automatic t_modes;
        int n;
        logic [15:0] a;
        int cyc [8] = '{2, 2, 2, 3, 4, 4, 4, 2};
        logic [15:0] lastA [8] = '{16'h1235, 16'h1235, 16'h1235, 16'h00F0, 16'h0010,
            16'h12F0, 16'h1321, 16'h1235};
        logic [15:0] nextA [8] = '{16'h1235, 16'h1235, 16'h1236, 16'h1236, 16'h1236,
            16'h1237, 16'h1237, 16'h1235};
        for (int i = 0; i < 8; i++) begin
            go(3'(i), i == 6, 1'b0);
            nValid = 0;
            n = 0;
            do begin
                a = addrOut;
                next_cyc();
                n++;
            end while (opFetch !== 1'b1 && n < 8);
            chk(16'(n), 16'(cyc[i]));
            chk(a, lastA[i]);
            chk(addrOut, nextA[i]);
            if (i >= 3 && i <= 6) chk(effAddrOut, lastA[i]);
            if (i == 2) chk(16'(operandOut), 16'h00F0);
            chk(16'(opcodeOut), 16'h00A5);
            chk(16'(nValid), 16'(i >= 2 && i <= 6));
        end
        $display("t_modes done");
    endtask : t_modes
    // store under hold, then frozen fetch, then release
    task t_store;
        go(MODE_ABS, 1'b0, 1'b1);
        repeat (3) next_cyc();
        chk(addrOut, 16'h12F0);
        chk(16'(readWrite), 16'h0000);
        chk(16'(dataOut), 16'h005A);
        chk(16'(dataOe), 16'h0001);
        // gate dropped for one clock, hold moves in phase one only
        @(posedge ref_clk);
        dataOutputGate <= 1'b0;
        holdIn <= 1'b0;
        @(posedge ref_clk);
        dataOutputGate <= 1'b1;
        #1;
        chk(16'(dataOe), 16'h0000);
        next_cyc();
        chk(addrOut, 16'h1237);
        chk(16'(opFetch), 16'h0001);
        chk(16'(dataOe), 16'h0000);
        next_cyc();
        chk(addrOut, 16'h1237);
        @(posedge ref_clk);
        holdIn <= 1'b1;
        next_cyc();
        chk(addrOut, 16'h1238);
        chk(16'(cbc_mem_model_inst.memArr[16'h12F0]), 16'h005A);
        $display("t_store done");
    endtask : t_store
    // interrupt entry: pushes, vector pair, fetch at target
    task t_int(input logic nmi);
        int n;
        go(MODE_IMPLIED, 1'b0, 1'b0);
        @(posedge ref_clk);
        statusLoad <= 1'b1;
        statusIn <= nmi ? 8'h04 : 8'h00;
        @(posedge ref_clk);
        statusLoad <= 1'b0;
        setOverflowN <= 1'b0;
        irqN <= nmi;
        nmiN <= !nmi;
        n = 0;
        do begin
            next_cyc();
            n++;
        end while (readWrite !== 1'b0 && n < 8);
        chk(addrOut, 16'h01FF);
        next_cyc();
        chk(addrOut, 16'h01FE);
        next_cyc();
        chk(addrOut, 16'h01FD);
        chk(16'(readWrite), 16'h0000);
        next_cyc();
        chk(addrOut, nmi ? VEC_NMI : VEC_IRQ);
        chk(16'(statusOut[STAT_MASK_BIT]), 16'h0001);
        next_cyc();
        chk(addrOut, nmi ? 16'hFFFB : 16'hFFFF);
        next_cyc();
        chk(addrOut, nmi ? 16'h3000 : 16'h2000);
        chk(16'(opFetch), 16'h0001);
        chk(16'(statusOut[STAT_OVF_BIT]), 16'h0001);
        @(posedge ref_clk);
        irqN <= 1'b1;
        nmiN <= 1'b1;
        setOverflowN <= 1'b1;
        $display("t_int done");
    endtask : t_int
    // watchdog
    initial begin
        #400000;
        err_count++;
        stop_test();
    end
    initial begin
        reset_n = 1'b0;
        resetInputN = 1'b0;
        holdIn = 1'b1;
        irqN = 1'b1;
        nmiN = 1'b1;
        setOverflowN = 1'b1;
        dataOutputGate = 1'b1;
        decodeMode = MODE_IMPLIED;
        decodeStore = 1'b0;
        decodeUseY = 1'b0;
        indexX = 8'h20;
        indexY = 8'h31;
        storeData = 8'h5A;
        statusLoad = 1'b0;
        statusIn = 8'h00;
        err_count = 0;
        n_tests = 0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_modes();
        t_store();
        t_int(1'b0);
        t_int(1'b1);
        stop_test();
    end
endmodule : cbc_bus_core_bench
`default_nettype wire
